// ### rtl/ddc0_cfg_defines.svh
// Register indices, field positions, masks and reset values for DDC 0
`ifndef DDC0_CFG_DEFINES_SVH
`define DDC0_CFG_DEFINES_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define DDC0_ADDR_W          14
`define DDC0_SAMPLE_W        14
`define DDC0_NCO_W           48

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define DDC0_IDX_SRC_SEL     12'h311
`define DDC0_IDX_FW0         12'h314
`define DDC0_IDX_FW1         12'h315
`define DDC0_IDX_FW2         12'h316
`define DDC0_IDX_FW3         12'h317
`define DDC0_IDX_FW4         12'h318
`define DDC0_IDX_FW5         12'h31A
`define DDC0_IDX_PO0         12'h31D
`define DDC0_IDX_PO1         12'h31E
`define DDC0_IDX_PO2         12'h31F
`define DDC0_IDX_PO3         12'h320
`define DDC0_IDX_PO4         12'h321
`define DDC0_IDX_PO5         12'h322
`define DDC0_IDX_TEST_EN     12'h327

// ****************************************************************
// Fields and writable masks
// ****************************************************************
`define DDC0_BIT_I_SEL       0
`define DDC0_BIT_Q_SEL       2
`define DDC0_BIT_Q_TEST      2
`define DDC0_MASK_SRC_SEL    8'h05
`define DDC0_MASK_TEST_EN    8'h04

// ****************************************************************
// Reset values
// ****************************************************************
`define DDC0_RST_SRC_SEL     8'h00
`define DDC0_RST_BYTE        8'h00
`define DDC0_RST_TEST_EN     8'h00

`endif

// ### rtl/ddc0_cfg_pkg.sv
// Types shared by the DDC 0 configuration block
`include "ddc0_cfg_defines.svh"

package ddc0_cfg_pkg;

	// ****************************************************************
	// Converter samples of the four channels
	// ****************************************************************
	typedef struct packed {
		logic [`DDC0_SAMPLE_W-1:0] a;
		logic [`DDC0_SAMPLE_W-1:0] b;
		logic [`DDC0_SAMPLE_W-1:0] c;
		logic [`DDC0_SAMPLE_W-1:0] d;
	} adc_in_t;

	// ****************************************************************
	// Decoded configuration
	// ****************************************************************
	typedef struct packed {
		logic                   i_sel;
		logic                   q_sel;
		logic                   q_test;
		logic [`DDC0_NCO_W-1:0] freq_word;
		logic [`DDC0_NCO_W-1:0] phase_offset;
	} ddc_cfg_t;

endpackage

// ### rtl/ddc0_nco.sv
// Phase accumulator with phase offset for the DDC 0 oscillator
`timescale 1ns/100ps
`include "ddc0_cfg_defines.svh"

module ddc0_nco
	import ddc0_cfg_pkg::*;
#(
	parameter int NCO_W = `DDC0_NCO_W
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             rst_n,
	// Configuration and sample strobe
	input  wire logic             sample_en,
	input  wire logic [NCO_W-1:0] freq_word,
	input  wire logic [NCO_W-1:0] phase_offset,
	// Oscillator state
	output logic      [NCO_W-1:0] phase_acc_reg,
	output logic      [NCO_W-1:0] nco_phase_reg
);

	// ****************************************************************
	// Accumulator
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			phase_acc_reg <= '0;
		end else if (sample_en) begin
			phase_acc_reg <= phase_acc_reg + freq_word;
		end
	end

	// ****************************************************************
	// Offset phase
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			nco_phase_reg <= '0;
		end else if (sample_en) begin
			nco_phase_reg <= phase_acc_reg + phase_offset;
		end
	end

endmodule

// ### rtl/ddc0_sample_route.sv
// Input channel selection and test pattern substitution for DDC 0
`timescale 1ns/100ps
`include "ddc0_cfg_defines.svh"

module ddc0_sample_route
	import ddc0_cfg_pkg::*;
#(
	parameter bit PAIR_CD = 1'b0
) (
	// Clock and reset
	input  wire logic                     mclk,
	input  wire logic                     rst_n,
	// Samples and controls
	input  wire logic                     sample_en,
	input  wire adc_in_t                  adc_in,
	input  wire logic [`DDC0_SAMPLE_W-1:0] test_bd,
	input  wire logic                     i_sel,
	input  wire logic                     q_sel,
	input  wire logic                     q_test,
	// Routed samples
	output logic      [`DDC0_SAMPLE_W-1:0] i_sample_reg,
	output logic      [`DDC0_SAMPLE_W-1:0] q_sample_reg
);

	logic [`DDC0_SAMPLE_W-1:0] q_src;

	always_comb begin
		if (q_sel) begin
			q_src = PAIR_CD ? adc_in.d : adc_in.b;
		end else begin
			q_src = PAIR_CD ? adc_in.c : adc_in.a;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			i_sample_reg <= '0;
			q_sample_reg <= '0;
		end else if (sample_en) begin
			i_sample_reg <= i_sel ? adc_in.b : adc_in.a;
			q_sample_reg <= q_test ? test_bd : q_src;
		end
	end

endmodule

// ### rtl/ddc0_cfg.sv
// DDC 0 oscillator and input configuration bank with APB slave
//
// Overview of operation
// - Q select bit picks A/C or B/D
// - I select bit picks channel A or B
// - Frequency word is six bytes, low first
// - Accumulator adds frequency word every sample
// - Six-byte phase offset adds to oscillator phase
// - Q test enable substitutes B/D test pattern
//
// Our own choice: the APB register port.
`timescale 1ns/100ps
`include "ddc0_cfg_defines.svh"

module ddc0_cfg
	import ddc0_cfg_pkg::*;
#(
	parameter bit PAIR_CD = 1'b0
) (
	// Clock and reset
	input  wire logic                      mclk,
	input  wire logic                      rst_n,
	// APB slave
	input  wire logic [`DDC0_ADDR_W-1:0]   paddr,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [31:0]               pwdata,
	input  wire logic [3:0]                pstrb,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	// Sample path
	input  wire logic                      sample_en,
	input  wire adc_in_t                   adc_in,
	input  wire logic [`DDC0_SAMPLE_W-1:0] test_bd,
	output logic      [`DDC0_SAMPLE_W-1:0] i_sample,
	output logic      [`DDC0_SAMPLE_W-1:0] q_sample,
	// Oscillator
	output logic      [`DDC0_NCO_W-1:0]    nco_phase,
	output logic      [`DDC0_NCO_W-1:0]    phase_acc
);

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	function automatic logic [11:0] reg_idx(input logic [`DDC0_ADDR_W-1:0] a);
		reg_idx = a[13:2];
	endfunction

	function automatic logic idx_mapped(input logic [11:0] idx);
		unique case (idx)
			`DDC0_IDX_SRC_SEL, `DDC0_IDX_TEST_EN,
			`DDC0_IDX_FW0, `DDC0_IDX_FW1, `DDC0_IDX_FW2,
			`DDC0_IDX_FW3, `DDC0_IDX_FW4, `DDC0_IDX_FW5,
			`DDC0_IDX_PO0, `DDC0_IDX_PO1, `DDC0_IDX_PO2,
			`DDC0_IDX_PO3, `DDC0_IDX_PO4, `DDC0_IDX_PO5: begin
				idx_mapped = 1'b1;
			end
			default: begin
				idx_mapped = 1'b0;
			end
		endcase
	endfunction

	// ****************************************************************
	// Storage
	// ****************************************************************
	logic [7:0]       src_sel_reg;
	logic [7:0]       test_en_reg;
	logic [7:0]       freq_reg [0:5];
	logic [7:0]       offs_reg [0:5];
	logic [11:0]      acc_idx;
	logic             write_fire;
	logic [31:0]      rd_next;
	ddc_cfg_t         cfg;

	assign acc_idx    = reg_idx(paddr);
	assign write_fire = psel && penable && pready && pwrite && pstrb[0];

	// ****************************************************************
	// APB handshake, one wait state
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (psel && penable && !pready) begin
			pready  <= 1'b1;
			pslverr <= !idx_mapped(acc_idx);
			prdata  <= pwrite ? 32'h00000000 : rd_next;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
	end

	// ****************************************************************
	// Read mux
	// ****************************************************************
	always_comb begin
		rd_next = 32'h00000000;
		unique case (acc_idx)
			`DDC0_IDX_SRC_SEL: begin
				rd_next[7:0] = src_sel_reg;
			end
			`DDC0_IDX_TEST_EN: begin
				rd_next[7:0] = test_en_reg;
			end
			`DDC0_IDX_FW0: begin
				rd_next[7:0] = freq_reg[0];
			end
			`DDC0_IDX_FW1: begin
				rd_next[7:0] = freq_reg[1];
			end
			`DDC0_IDX_FW2: begin
				rd_next[7:0] = freq_reg[2];
			end
			`DDC0_IDX_FW3: begin
				rd_next[7:0] = freq_reg[3];
			end
			`DDC0_IDX_FW4: begin
				rd_next[7:0] = freq_reg[4];
			end
			`DDC0_IDX_FW5: begin
				rd_next[7:0] = freq_reg[5];
			end
			`DDC0_IDX_PO0: begin
				rd_next[7:0] = offs_reg[0];
			end
			`DDC0_IDX_PO1: begin
				rd_next[7:0] = offs_reg[1];
			end
			`DDC0_IDX_PO2: begin
				rd_next[7:0] = offs_reg[2];
			end
			`DDC0_IDX_PO3: begin
				rd_next[7:0] = offs_reg[3];
			end
			`DDC0_IDX_PO4: begin
				rd_next[7:0] = offs_reg[4];
			end
			`DDC0_IDX_PO5: begin
				rd_next[7:0] = offs_reg[5];
			end
			default: begin
				rd_next = 32'h00000000;
			end
		endcase
	end

	// ****************************************************************
	// Select and test registers
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			src_sel_reg <= `DDC0_RST_SRC_SEL;
			test_en_reg <= `DDC0_RST_TEST_EN;
		end else if (write_fire) begin
			if (acc_idx == `DDC0_IDX_SRC_SEL) begin
				src_sel_reg <= pwdata[7:0] & `DDC0_MASK_SRC_SEL;
			end
			if (acc_idx == `DDC0_IDX_TEST_EN) begin
				test_en_reg <= pwdata[7:0] & `DDC0_MASK_TEST_EN;
			end
		end
	end

	// ****************************************************************
	// Frequency word and phase offset bytes
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			for (int k = 0; k < 6; k++) begin
				freq_reg[k] <= `DDC0_RST_BYTE;
				offs_reg[k] <= `DDC0_RST_BYTE;
			end
		end else if (write_fire) begin
			unique case (acc_idx)
				`DDC0_IDX_FW0: freq_reg[0] <= pwdata[7:0];
				`DDC0_IDX_FW1: freq_reg[1] <= pwdata[7:0];
				`DDC0_IDX_FW2: freq_reg[2] <= pwdata[7:0];
				`DDC0_IDX_FW3: freq_reg[3] <= pwdata[7:0];
				`DDC0_IDX_FW4: freq_reg[4] <= pwdata[7:0];
				`DDC0_IDX_FW5: freq_reg[5] <= pwdata[7:0];
				`DDC0_IDX_PO0: offs_reg[0] <= pwdata[7:0];
				`DDC0_IDX_PO1: offs_reg[1] <= pwdata[7:0];
				`DDC0_IDX_PO2: offs_reg[2] <= pwdata[7:0];
				`DDC0_IDX_PO3: offs_reg[3] <= pwdata[7:0];
				`DDC0_IDX_PO4: offs_reg[4] <= pwdata[7:0];
				`DDC0_IDX_PO5: offs_reg[5] <= pwdata[7:0];
				default: begin
				end
			endcase
		end
	end

	// ****************************************************************
	// Configuration bundle
	// ****************************************************************
	always_comb begin
		cfg.i_sel        = src_sel_reg[`DDC0_BIT_I_SEL];
		cfg.q_sel        = src_sel_reg[`DDC0_BIT_Q_SEL];
		cfg.q_test       = test_en_reg[`DDC0_BIT_Q_TEST];
		cfg.freq_word    = {freq_reg[5], freq_reg[4], freq_reg[3],
		                    freq_reg[2], freq_reg[1], freq_reg[0]};
		cfg.phase_offset = {offs_reg[5], offs_reg[4], offs_reg[3],
		                    offs_reg[2], offs_reg[1], offs_reg[0]};
	end

	// ****************************************************************
	// Oscillator and routing
	// ****************************************************************
	ddc0_nco #(
		.NCO_W         (`DDC0_NCO_W)
	) ddc0_nco_inst (
		.mclk          (mclk),
		.rst_n         (rst_n),
		.sample_en     (sample_en),
		.freq_word     (cfg.freq_word),
		.phase_offset  (cfg.phase_offset),
		.phase_acc_reg (phase_acc),
		.nco_phase_reg (nco_phase)
	);

	ddc0_sample_route #(
		.PAIR_CD      (PAIR_CD)
	) ddc0_sample_route_inst (
		.mclk         (mclk),
		.rst_n        (rst_n),
		.sample_en    (sample_en),
		.adc_in       (adc_in),
		.test_bd      (test_bd),
		.i_sel        (cfg.i_sel),
		.q_sel        (cfg.q_sel),
		.q_test       (cfg.q_test),
		.i_sample_reg (i_sample),
		.q_sample_reg (q_sample)
	);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	logic [`DDC0_SAMPLE_W-1:0] q_expect;
	logic [`DDC0_SAMPLE_W-1:0] i_expect;

	always_comb begin
		if (cfg.q_sel) begin
			q_expect = PAIR_CD ? adc_in.d : adc_in.b;
		end else begin
			q_expect = PAIR_CD ? adc_in.c : adc_in.a;
		end
		i_expect = cfg.i_sel ? adc_in.b : adc_in.a;
	end

	a_q_route_sel: assert property (
		sample_en && !cfg.q_test |=> q_sample == $past(q_expect))
		else $error("Q path source does not follow select bit");

	a_i_route_sel: assert property (
		sample_en |=> i_sample == $past(i_expect))
		else $error("I path source does not follow select bit");

	a_freq_top_byte: assert property (
		write_fire && acc_idx == `DDC0_IDX_FW5
		|=> cfg.freq_word[47:40] == $past(pwdata[7:0]))
		else $error("Top frequency byte not placed in bits 47:40");

	a_freq_low_byte: assert property (
		write_fire && acc_idx == `DDC0_IDX_FW0
		|=> cfg.freq_word[7:0] == $past(pwdata[7:0]))
		else $error("Low frequency byte not placed in bits 7:0");

	a_acc_step_add: assert property (
		sample_en |=> phase_acc == $past(phase_acc) + $past(cfg.freq_word))
		else $error("Accumulator did not advance by frequency word");

	a_acc_hold_idle: assert property (
		!sample_en |=> $stable(phase_acc))
		else $error("Accumulator moved without a sample");

	a_phase_offs_add: assert property (
		sample_en
		|=> nco_phase == $past(phase_acc) + $past(cfg.phase_offset))
		else $error("Phase offset not added to oscillator phase");

	a_q_test_sub: assert property (
		sample_en && cfg.q_test |=> q_sample == $past(test_bd))
		else $error("Q test pattern not substituted");

	a_rsvd_read_zero: assert property (
		pready && !pslverr
		|-> prdata[31:8] == 24'h000000 && src_sel_reg[7:3] == 5'h00
		    && src_sel_reg[1] == 1'b0 && test_en_reg[7:3] == 5'h00
		    && test_en_reg[1:0] == 2'h0)
		else $error("Reserved bits not zero");

	a_apb_one_wait: assert property (
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("APB answer not after exactly one wait state");

	a_apb_unmapped: assert property (
		psel && penable && !pready && !idx_mapped(acc_idx)
		|=> pslverr && prdata == 32'h00000000)
		else $error("Unmapped access not flagged");

	c_freq_write: cover property (
		write_fire && acc_idx == `DDC0_IDX_FW5);
	c_q_test_sample: cover property (
		sample_en && cfg.q_test ##1 sample_en);
	c_unmapped_err: cover property (pready && pslverr);
	c_read_offset: cover property (
		pready && !pwrite && acc_idx == `DDC0_IDX_PO5);

endmodule

// ### sim/ddc0_nco_input_config_bench.sv
// Self-checking testbench for the DDC 0 configuration bank
`timescale 1ns/100ps
`include "ddc0_cfg_defines.svh"

module ddc0_nco_input_config_bench
	import ddc0_cfg_pkg::*;
;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic                      mclk;
	logic                      rst_n;
	logic [`DDC0_ADDR_W-1:0]   paddr;
	logic                      psel;
	logic                      penable;
	logic                      pwrite;
	logic [31:0]               pwdata;
	logic [3:0]                pstrb;
	logic [31:0]               prdata;
	logic                      pready;
	logic                      pslverr;
	logic                      sample_en;
	adc_in_t                   adc_in;
	logic [`DDC0_SAMPLE_W-1:0] test_bd;
	logic [`DDC0_SAMPLE_W-1:0] i_sample;
	logic [`DDC0_SAMPLE_W-1:0] q_sample;
	logic [`DDC0_SAMPLE_W-1:0] q_sample_cd;
	logic [`DDC0_NCO_W-1:0]    nco_phase;
	logic [`DDC0_NCO_W-1:0]    phase_acc;
	int                        errors;
	int                        cmp_count;
	int                        cycles;

	// Register indices: source, six freq bytes, six offset bytes, test
	localparam logic [11:0] IDX_TAB [14] = '{
		`DDC0_IDX_SRC_SEL, `DDC0_IDX_FW0, `DDC0_IDX_FW1, `DDC0_IDX_FW2,
		`DDC0_IDX_FW3, `DDC0_IDX_FW4, `DDC0_IDX_FW5, `DDC0_IDX_PO0,
		`DDC0_IDX_PO1, `DDC0_IDX_PO2, `DDC0_IDX_PO3, `DDC0_IDX_PO4,
		`DDC0_IDX_PO5, `DDC0_IDX_TEST_EN};

	ddc0_cfg #(.PAIR_CD(1'b0)) ddc0_cfg_inst (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.paddr    (paddr),
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.pwdata   (pwdata),
		.pstrb    (pstrb),
		.prdata   (prdata),
		.pready   (pready),
		.pslverr  (pslverr),
		.sample_en(sample_en),
		.adc_in   (adc_in),
		.test_bd  (test_bd),
		.i_sample (i_sample),
		.q_sample (q_sample),
		.nco_phase(nco_phase),
		.phase_acc(phase_acc)
	);

	// Second copy on the same bus, Q path paired with C/D
	ddc0_cfg #(.PAIR_CD(1'b1)) ddc0_cfg_cd_inst (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.paddr    (paddr),
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.pwdata   (pwdata),
		.pstrb    (pstrb),
		.prdata   (),
		.pready   (),
		.pslverr  (),
		.sample_en(sample_en),
		.adc_in   (adc_in),
		.test_bd  (test_bd),
		.i_sample (),
		.q_sample (q_sample_cd),
		.nco_phase(),
		.phase_acc()
	);

	always #2 mclk = ~mclk;

	// ****************************************************************
	// Reporting
	// ****************************************************************
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			errors++;
			conclude();
		end
	end

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_val(input logic [47:0] got, input logic [47:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// ****************************************************************
	// Bus and sample drivers
	// ****************************************************************
	task automatic apb(input logic [11:0] idx, input logic wr,
		input logic [31:0] wd, input logic [3:0] strb,
		output logic [31:0] rd, output logic err);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= {idx, 2'h0};
		pwrite  <= wr;
		pwdata  <= wd;
		pstrb   <= strb;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			errors++;
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic reg_wr(input logic [11:0] idx, input logic [31:0] wd,
		input logic [3:0] strb, input logic experr);
		logic [31:0] rd;
		logic        err;
		apb(idx, 1'b1, wd, strb, rd, err);
		chk_word({31'h0, err}, {31'h0, experr});
	endtask

	task automatic reg_rd(input logic [11:0] idx, input logic [31:0] exp,
		input logic experr);
		logic [31:0] rd;
		logic        err;
		apb(idx, 1'b0, 32'h0, 4'h0, rd, err);
		chk_word(rd, exp);
		chk_word({31'h0, err}, {31'h0, experr});
	endtask

	task automatic pulse(input int n);
		sample_en <= 1'b1;
		repeat (n) @(posedge mclk);
		sample_en <= 1'b0;
		@(posedge mclk);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic reset_values();
		for (int i = 0; i < 14; i++) begin
			reg_rd(IDX_TAB[i], 32'h0, 1'b0);
		end
	endtask

	task automatic reserved_bits();
		reg_wr(IDX_TAB[0], 32'hFF, 4'hF, 1'b0);
		reg_rd(IDX_TAB[0], 32'h05, 1'b0);
		reg_wr(IDX_TAB[13], 32'hFF, 4'hF, 1'b0);
		reg_rd(IDX_TAB[13], 32'h04, 1'b0);
		reg_wr(IDX_TAB[13], 32'h0, 4'hF, 1'b0);
		reg_wr(IDX_TAB[1], 32'hFFFFFF12, 4'hF, 1'b0);
		reg_rd(IDX_TAB[1], 32'h12, 1'b0);
		reg_wr(IDX_TAB[1], 32'hAA, 4'hE, 1'b0);
		reg_rd(IDX_TAB[1], 32'h12, 1'b0);
		reg_wr(12'h319, 32'h55, 4'hF, 1'b1);
		reg_rd(12'h312, 32'h0, 1'b1);
		reg_rd(IDX_TAB[6], 32'h0, 1'b0);
	endtask

	task automatic routing();
		logic [1:0] s;
		adc_in  <= {14'h0AAA, 14'h0BBB, 14'h0CCC, 14'h0DDD};
		test_bd <= 14'h1234;
		for (int k = 0; k < 4; k++) begin
			s = k[1:0];
			reg_wr(IDX_TAB[0], {29'h0, s[1], 1'b0, s[0]}, 4'hF, 1'b0);
			pulse(1);
			chk_word({18'h0, i_sample}, s[0] ? 32'h0BBB : 32'h0AAA);
			chk_word({18'h0, q_sample}, s[1] ? 32'h0BBB : 32'h0AAA);
			chk_word({18'h0, q_sample_cd}, s[1] ? 32'h0DDD : 32'h0CCC);
		end
		reg_wr(IDX_TAB[13], 32'h04, 4'hF, 1'b0);
		pulse(1);
		chk_word({18'h0, q_sample}, 32'h1234);
		chk_word({18'h0, i_sample}, 32'h0BBB);
		reg_wr(IDX_TAB[13], 32'h0, 4'hF, 1'b0);
		pulse(1);
		chk_word({18'h0, q_sample}, 32'h0BBB);
	endtask

	task automatic oscillator();
		logic [47:0] fw;
		logic [47:0] po;
		logic [47:0] a0;
		fw = 48'hF123_4567_89AB;
		po = 48'h0102_0304_0506;
		for (int k = 0; k < 6; k++) begin
			reg_wr(IDX_TAB[1+k], {24'h0, fw[8*k+:8]}, 4'hF, 1'b0);
			reg_wr(IDX_TAB[7+k], {24'h0, po[8*k+:8]}, 4'hF, 1'b0);
		end
		reg_rd(IDX_TAB[6], 32'hF1, 1'b0);
		// Six earlier samples stepped by the low byte 0x12 alone
		a0 = 48'h0000_0000_006C;
		chk_val(phase_acc, a0);
		pulse(3);
		chk_val(phase_acc, a0 + fw + fw + fw);
		chk_val(nco_phase, a0 + fw + fw + po);
	endtask

	task automatic mid_reset();
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		chk_val(phase_acc, 48'h0);
		chk_val(nco_phase, 48'h0);
		chk_word({18'h0, q_sample}, 32'h0);
		reset_values();
	endtask

	initial begin
		mclk      = 1'b0;
		rst_n     = 1'b0;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = '0;
		pwdata    = 32'h0;
		pstrb     = 4'h0;
		sample_en = 1'b0;
		adc_in    = '0;
		test_bd   = '0;
		errors    = 0;
		cmp_count = 0;
		cycles    = 0;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		reset_values();
		reserved_bits();
		routing();
		oscillator();
		mid_reset();
		conclude();
	end
endmodule
